// >>> include/gpfs_regs.vh
// register map, field layout and function codes of the pin function selector
`ifndef GPFS_REGS_VH
`define GPFS_REGS_VH

`define GPFS_ADDR_W 12
`define GPFS_FUNC_SEL_IDX 10'h023
`define GPFS_WARN_EN_IDX 10'h030
`define GPFS_STATUS_IDX 10'h031

`define GPFS_FUNC_SEL_RST 8'h00
`define GPFS_WARN_EN_RST 6'h00
`define GPFS_WARN_SRC_W 6

`define GPFS_PIN1_LSB 0
`define GPFS_PIN2_LSB 4

`define GPFS_CODE_HIZ 4'h0
`define GPFS_CODE_WARN 4'h1
`define GPFS_CODE_FAULT 4'h2
`define GPFS_CODE_CLIP1 4'h3
`define GPFS_CODE_CLIP2 4'h4
`define GPFS_CODE_SYNC_OUT 4'h5
`define GPFS_CODE_HIGH 4'h6
`define GPFS_CODE_LOW 4'h7
`define GPFS_CODE_SYNC_IN 4'h8
`define GPFS_CODE_MUTE 4'h9

`define GPFS_ST_WARN 0
`define GPFS_ST_FAULT 1
`define GPFS_ST_MUTE 2
`define GPFS_ST_SYNC_SEL 3
`define GPFS_ST_PIN1 4
`define GPFS_ST_PIN2 5

`define GPFS_RESP_OKAY 2'h0
`define GPFS_RESP_SLVERR 2'h2

`endif

// >>> logic/gpfs_warn_merge.v
// registered merge of enabled warning sources and the fault signal
`timescale 1ns/1ps
module gpfs_warn_merge #(
  parameter SRC_W = 6
) (
  input wire core_clk,
  input wire rst,
  input wire [SRC_W-1:0] warn_src,
  input wire [SRC_W-1:0] warn_en,
  input wire fault_in,
  output reg warn_r,
  output reg fault_r
);

always @(posedge core_clk) begin
  if (rst) begin
    warn_r <= 1'b0;
    fault_r <= 1'b0;
  end else begin
    warn_r <= |(warn_src & warn_en);
    fault_r <= fault_in;
  end
end

endmodule // gpfs_warn_merge

// >>> logic/gpfs_pin_cell.v
// combinational decode of one pin's function code
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_pin_cell (
  input wire [3:0] code,
  input wire warn,
  input wire fault,
  input wire clip1,
  input wire clip2,
  input wire sw_freq,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg mute_req,
  output reg sync_sel
);

always @* begin
  pin_out = 1'b0;
  pin_oe = 1'b0;
  mute_req = 1'b0;
  sync_sel = 1'b0;
  case (code)
    `GPFS_CODE_WARN: begin
      pin_oe = warn;
    end
    `GPFS_CODE_FAULT: begin
      pin_oe = fault;
    end
    `GPFS_CODE_CLIP1: begin
      pin_oe = 1'b1;
      pin_out = clip1;
    end
    `GPFS_CODE_CLIP2: begin
      pin_oe = 1'b1;
      pin_out = clip2;
    end
    `GPFS_CODE_SYNC_OUT: begin
      pin_oe = 1'b1;
      pin_out = sw_freq;
    end
    `GPFS_CODE_HIGH: begin
      pin_oe = 1'b1;
      pin_out = 1'b1;
    end
    `GPFS_CODE_LOW: begin
      pin_oe = 1'b1;
    end
    `GPFS_CODE_SYNC_IN: begin
      sync_sel = 1'b1;
    end
    `GPFS_CODE_MUTE: begin
      mute_req = ~pin_in;
    end
    default: begin
      pin_oe = 1'b0;
    end
  endcase
end

endmodule // gpfs_pin_cell

// >>> logic/gpfs_top.v
// pin function selector: axi4-lite registers, two pin decoders, pin drivers
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_top #(
  parameter SRC_W = `GPFS_WARN_SRC_W
) (
  input wire core_clk,
  input wire rst,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`GPFS_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [`GPFS_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire [SRC_W-1:0] warn_src,
  input wire fault_in,
  input wire clip_grp1,
  input wire clip_grp2,
  input wire sw_freq,
  input wire [1:0] pin_in,
  output reg [1:0] pin_out,
  output reg [1:0] pin_oe,
  output reg mute_out,
  output reg sync_ext_sel,
  output reg sync_ext_clk
);

////////////////////////////////////////////////////////////////////////
// register addresses: byte address is four times the register index

localparam [`GPFS_ADDR_W-1:0] FUNC_SEL_ADDR = {`GPFS_FUNC_SEL_IDX, 2'b00};
localparam [`GPFS_ADDR_W-1:0] WARN_EN_ADDR = {`GPFS_WARN_EN_IDX, 2'b00};
localparam [`GPFS_ADDR_W-1:0] STATUS_ADDR = {`GPFS_STATUS_IDX, 2'b00};

reg [7:0] func_sel_r;
reg [SRC_W-1:0] warn_en_r;
reg aw_have_r;
reg w_have_r;
reg [`GPFS_ADDR_W-1:0] aw_addr_r;
reg [7:0] w_byte_r;
reg w_strb0_r;
reg arready_r;
reg awready_r;
reg wready_r;

wire aw_take;
wire w_take;
wire aw_now;
wire w_now;
wire [`GPFS_ADDR_W-1:0] wr_addr;
wire [7:0] wr_byte;
wire wr_strb0;
wire wr_fire;
wire bvalid_nxt;
wire aw_have_nxt;
wire w_have_nxt;
wire rd_take;
wire warn;
wire fault;
wire [1:0] cell_out;
wire [1:0] cell_oe;
wire [1:0] cell_mute;
wire [1:0] cell_sync;
wire [7:0] status;

////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order

// holding each half separately lets a master present them on any cycle
assign s_axi_awready = awready_r;
assign s_axi_wready = wready_r;
assign aw_take = s_axi_awvalid & s_axi_awready;
assign w_take = s_axi_wvalid & s_axi_wready;
assign aw_now = aw_have_r | aw_take;
assign w_now = w_have_r | w_take;
assign wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
assign wr_byte = w_have_r ? w_byte_r : s_axi_wdata[7:0];
assign wr_strb0 = w_have_r ? w_strb0_r : s_axi_wstrb[0];
assign wr_fire = aw_now & w_now & ~s_axi_bvalid;
assign bvalid_nxt = wr_fire | (s_axi_bvalid & ~s_axi_bready);
assign aw_have_nxt = ~wr_fire & (aw_have_r | aw_take);
assign w_have_nxt = ~wr_fire & (w_have_r | w_take);

// ready flops load from next values: ports stay registered, yet still mean
// half not held and no response pending, with no extra cycle of latency
always @(posedge core_clk) begin
  if (rst) begin
    awready_r <= 1'b1;
    wready_r <= 1'b1;
  end else begin
    awready_r <= ~aw_have_nxt & ~bvalid_nxt;
    wready_r <= ~w_have_nxt & ~bvalid_nxt;
  end
end

always @(posedge core_clk) begin
  if (rst) begin
    aw_have_r <= 1'b0;
    aw_addr_r <= {`GPFS_ADDR_W{1'b0}};
  end else if (wr_fire) begin
    aw_have_r <= 1'b0;
  end else if (aw_take) begin
    aw_have_r <= 1'b1;
    aw_addr_r <= s_axi_awaddr;
  end
end

always @(posedge core_clk) begin
  if (rst) begin
    w_have_r <= 1'b0;
    w_byte_r <= 8'h00;
    w_strb0_r <= 1'b0;
  end else if (wr_fire) begin
    w_have_r <= 1'b0;
  end else if (w_take) begin
    w_have_r <= 1'b1;
    w_byte_r <= s_axi_wdata[7:0];
    w_strb0_r <= s_axi_wstrb[0];
  end
end

always @(posedge core_clk) begin
  if (rst) begin
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `GPFS_RESP_OKAY;
  end else if (wr_fire) begin
    s_axi_bvalid <= 1'b1;
    if (wr_addr[`GPFS_ADDR_W-1:2] == FUNC_SEL_ADDR[`GPFS_ADDR_W-1:2] ||
        wr_addr[`GPFS_ADDR_W-1:2] == WARN_EN_ADDR[`GPFS_ADDR_W-1:2] ||
        wr_addr[`GPFS_ADDR_W-1:2] == STATUS_ADDR[`GPFS_ADDR_W-1:2]) begin
      s_axi_bresp <= `GPFS_RESP_OKAY;
    end else begin
      s_axi_bresp <= `GPFS_RESP_SLVERR;
    end
  end else if (s_axi_bready) begin
    s_axi_bvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// register file

// only byte lane 0 carries data; upper lanes are ignored
always @(posedge core_clk) begin
  if (rst) begin
    func_sel_r <= `GPFS_FUNC_SEL_RST;
    warn_en_r <= `GPFS_WARN_EN_RST;
  end else if (wr_fire && wr_strb0) begin
    if (wr_addr[`GPFS_ADDR_W-1:2] == FUNC_SEL_ADDR[`GPFS_ADDR_W-1:2]) begin
      func_sel_r <= wr_byte;
    end
    if (wr_addr[`GPFS_ADDR_W-1:2] == WARN_EN_ADDR[`GPFS_ADDR_W-1:2]) begin
      warn_en_r <= wr_byte[SRC_W-1:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// read channel: one read at a time, data one cycle after the address

assign s_axi_arready = arready_r;
assign rd_take = s_axi_arvalid & arready_r;

always @(posedge core_clk) begin
  if (rst) begin
    arready_r <= 1'b1;
  end else if (rd_take) begin
    arready_r <= 1'b0;
  end else if (s_axi_rvalid && s_axi_rready) begin
    arready_r <= 1'b1;
  end
end

always @(posedge core_clk) begin
  if (rst) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `GPFS_RESP_OKAY;
  end else if (rd_take) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `GPFS_RESP_OKAY;
    case (s_axi_araddr[`GPFS_ADDR_W-1:2])
      FUNC_SEL_ADDR[`GPFS_ADDR_W-1:2]: begin
        s_axi_rdata <= {24'h000000, func_sel_r};
      end
      WARN_EN_ADDR[`GPFS_ADDR_W-1:2]: begin
        s_axi_rdata <= {{(32-SRC_W){1'b0}}, warn_en_r};
      end
      STATUS_ADDR[`GPFS_ADDR_W-1:2]: begin
        s_axi_rdata <= {24'h000000, status};
      end
      default: begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `GPFS_RESP_SLVERR;
      end
    endcase
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// warning and fault sources

gpfs_warn_merge #(
  .SRC_W(SRC_W)
) u_warn (
  .core_clk(core_clk),
  .rst(rst),
  .warn_src(warn_src),
  .warn_en(warn_en_r),
  .fault_in(fault_in),
  .warn_r(warn),
  .fault_r(fault)
);

////////////////////////////////////////////////////////////////////////
// per-pin decode; each pin sees only its own nibble

genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
    gpfs_pin_cell u_cell (
      .code(func_sel_r[4*gi+3:4*gi]),
      .warn(warn),
      .fault(fault),
      .clip1(clip_grp1),
      .clip2(clip_grp2),
      .sw_freq(sw_freq),
      .pin_in(pin_in[gi]),
      .pin_out(cell_out[gi]),
      .pin_oe(cell_oe[gi]),
      .mute_req(cell_mute[gi]),
      .sync_sel(cell_sync[gi])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// pin drivers and input functions

// sync out is resampled on core_clk, so its edges carry up to 5 ns jitter
always @(posedge core_clk) begin
  if (rst) begin
    pin_out <= 2'b00;
    pin_oe <= 2'b00;
    mute_out <= 1'b0;
    sync_ext_sel <= 1'b0;
    sync_ext_clk <= 1'b0;
  end else begin
    pin_out <= cell_out;
    pin_oe <= cell_oe;
    mute_out <= |cell_mute;
    sync_ext_sel <= |cell_sync;
    // pin one wins if both pins are set to sync in
    sync_ext_clk <= cell_sync[0] ? pin_in[0] : (cell_sync[1] & pin_in[1]);
  end
end

assign status = {2'b00, pin_in[1], pin_in[0], sync_ext_sel, mute_out, fault, warn};

endmodule // gpfs_top

// >>> dv/gpfs_chk.sv
// port-level assertions for the pin function selector
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_chk (
  input wire core_clk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [`GPFS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [`GPFS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire [1:0] pin_in,
  input wire [1:0] pin_oe,
  input wire mute_out,
  input wire sync_ext_sel,
  input wire sync_ext_clk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic bit bad(input [11:0] a);
    bad = a != 12'h08C && a != 12'h0C0 && a != 12'h0C4;
  endfunction
  sequence wr_tk;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_tk;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  wr_resp_a: assert property (wr_tk |=> s_axi_bvalid)
    else $error("no write response after take");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_resp_a: assert property (ar_tk |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response after take");
  bad_wr_a: assert property ((wr_tk ##0 bad(s_axi_awaddr)) |=> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  bad_rd_a: assert property ((ar_tk ##0 bad(s_axi_araddr)) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  rst_idle_a: assert property ($past(rst) |-> pin_oe == 2'h0 && !mute_out && !sync_ext_sel)
    else $error("pins not idle after reset");
  mute_cause_a: assert property (mute_out |-> $past(pin_in) != 2'h3 && pin_oe != 2'h3)
    else $error("mute without a low input pin");
  sync_clk_a: assert property (sync_ext_clk |-> sync_ext_sel)
    else $error("sync clock without sync select");
  sync_in_a: assert property (sync_ext_sel |-> pin_oe != 2'h3)
    else $error("sync input pin is driven");
endmodule // gpfs_chk
bind gpfs_top gpfs_chk u_chk (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .pin_in(pin_in), .pin_oe(pin_oe), .mute_out(mute_out),
  .sync_ext_sel(sync_ext_sel), .sync_ext_clk(sync_ext_clk));

// >>> dv/gpfs_pin_far.sv
// far-side model: external drivers and pull-ups on the two pins
`timescale 1ns/1ps
module gpfs_pin_far (
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe,
  input wire [1:0] ext_en,
  input wire [1:0] ext_val,
  output wire [1:0] pin_in
);
  // released pin goes to ext_val if ext_en is set, else to the pull-up; never keeps the last value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule // gpfs_pin_far

// >>> dv/gpio_pin_function_select_tb.sv
// self-checking bench for the pin function selector
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpio_pin_function_select_tb;
  localparam [11:0] A_SEL = 12'h08C;
  localparam [11:0] A_EN = 12'h0C0;
  reg core_clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  reg flt = 0, c1 = 0, c2 = 0, swf = 0;
  reg [11:0] awa = 0, ara = 0;
  reg [31:0] wd = 0, rdv;
  reg [5:0] wsrc = 0;
  reg [3:0] c;
  reg [1:0] xen = 0, xval = 0, rr, e1, e2;
  wire awr, wrd, bv, arr, rv, mute, sel, sclk;
  wire [1:0] bresp, rresp, pin_in, pin_out, pin_oe;
  wire [31:0] rdata;
  integer miscompares = 0, n_checks = 0, i;
  gpfs_top u_dut (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .warn_src(wsrc), .fault_in(flt), .clip_grp1(c1), .clip_grp2(c2), .sw_freq(swf), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .mute_out(mute), .sync_ext_sel(sel), .sync_ext_clk(sclk));
  gpfs_pin_far u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(xen), .ext_val(xval), .pin_in(pin_in));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // st delays bready so the response must wait for it
  task wr(input [11:0] a, input [31:0] d, input [1:0] er, input integer st);
    integer n;
    begin
      @(posedge core_clk);
      awa <= a; wd <= d; awv <= 1; wv <= 1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge core_clk);
        if (awr) awv <= 0;
        if (wrd) wv <= 0;
        if (bv && bready) begin
          bready <= 0;
          chk(bresp, er);
          n = 99;
        end else bready <= (n >= st);
      end
      if (n != 100) begin miscompares = miscompares + 1; give_verdict; end
    end
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    integer n;
    begin
      @(posedge core_clk);
      ara <= a; arv <= 1; rready <= 1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge core_clk);
        if (arr) arv <= 0;
        if (rv) begin rready <= 0; d = rdata; r = rresp; n = 99; end
      end
      if (n != 100) begin miscompares = miscompares + 1; give_verdict; end
    end
  endtask
  task settle;
    repeat (3) @(posedge core_clk);
  endtask
  // pin level expected for one code: {driven, level}
  function [1:0] ef(input [3:0] k, input l);
    case (k)
      4'h1, 4'h2: ef = l ? 2'h2 : 2'h0;
      4'h3, 4'h4, 4'h5: ef = {1'b1, l};
      4'h6: ef = 2'h3;
      4'h7: ef = 2'h2;
      default: ef = 2'h0;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    rd(A_SEL, rdv, rr);
    chk(rdv, 32'h0);
    chk(rr, 2'h0);
    wr(A_EN, 32'h3F, 2'h0, 0);
    // pin two gets the complement code so both nibbles sweep at once
    for (i = 0; i < 32; i = i + 1) begin
      c = i[4:1];
      wsrc <= {6{i[0]}}; flt <= i[0]; c1 <= i[0]; c2 <= i[0]; swf <= i[0];
      wr(A_SEL, {24'h0, ~c, c}, 2'h0, 0);
      settle;
      e1 = ef(c, i[0]);
      e2 = ef(~c, i[0]);
      chk({pin_oe, pin_oe & pin_out}, {e2[1], e1[1], e2[0], e1[0]});
    end
    wsrc <= 6'h20; flt <= 0;
    wr(A_EN, 32'h1F, 2'h0, 3);
    wr(A_SEL, 32'h01, 2'h0, 0);
    settle;
    chk(pin_oe[0], 1'b0);
    wr(A_EN, 32'h20, 2'h0, 0);
    settle;
    chk({pin_oe[0], pin_out[0]}, 2'h2);
    xen <= 2'h3; xval <= 2'h2;
    wr(A_SEL, 32'h89, 2'h0, 0);
    settle;
    chk({mute, sel, sclk}, 3'h7);
    xval <= 2'h1;
    settle;
    chk({mute, sel, sclk}, 3'h2);
    rd({`GPFS_STATUS_IDX, 2'b00}, rdv, rr);
    chk(rdv, 32'h19);
    rd(A_EN, rdv, rr);
    chk(rdv, 32'h20);
    rd(A_SEL, rdv, rr);
    chk(rdv, 32'h89);
    wr(12'h004, 32'hFF, 2'h2, 0);
    rd(12'h004, rdv, rr);
    chk(rdv, 32'h0);
    chk(rr, 2'h2);
    // second reset mid-run must bring select, enable and pins back to idle
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    rd(A_SEL, rdv, rr);
    chk(rdv, 32'h0);
    chk({pin_oe, mute, sel}, 4'h0);
    rd(A_EN, rdv, rr);
    chk(rdv, 32'h0);
    give_verdict;
  end
endmodule // gpio_pin_function_select_tb
